// ### sdac_map.vh
// register offsets, field positions and reset values of the audio config block
`ifndef SDAC_MAP_VH
`define SDAC_MAP_VH

`define SDAC_ADDR_W 8
`define SDAC_OFF_ENABLE 8'h00
`define SDAC_OFF_SOFT_RESET 8'h04
`define SDAC_OFF_IRQ_ENABLE 8'h0C
`define SDAC_OFF_IRQ_STATUS 8'h10
`define SDAC_OFF_AUDIO_CTRL 8'h18
`define SDAC_OFF_CHAN_LIMIT 8'h1C
`define SDAC_OFF_GROUP_SEL1 8'h20
`define SDAC_OFF_GROUP_SEL2 8'h24
`define SDAC_OFF_GROUP_SEL3 8'h28
`define SDAC_OFF_GROUP_SEL4 8'h2C
`define SDAC_OFF_GROUP_PRESENT 8'h40
`define SDAC_OFF_CTRL_PKT 8'h44
`define SDAC_OFF_CS_FIRST 8'h48
`define SDAC_OFF_CS_LAST 8'h5C
`define SDAC_OFF_OPTIONS 8'hFC

`define SDAC_SOFT_CFG_BIT 0
`define SDAC_SOFT_CORE_BIT 1
`define SDAC_OPT_CS_BIT 8
`define SDAC_OPT_LITE_BIT 7
`define SDAC_OPT_FUNC_BIT 6
`define SDAC_OPT_STD_MSB 5
`define SDAC_OPT_STD_LSB 4
`define SDAC_OPT_MAXCH_MSB 3
`define SDAC_OPT_MAXCH_LSB 0

`define SDAC_NUM_EVENTS 6
`define SDAC_NUM_CS_WORDS 6
`define SDAC_CLK_PHASE_RESET 1'h1
`define SDAC_LIMIT_GROUP1 5'h04
`define SDAC_LIMIT_GROUP2 5'h08
`define SDAC_LIMIT_GROUP3 5'h0C

`define SDAC_RESP_OKAY 2'h0
`define SDAC_RESP_SLVERR 2'h2

`endif

// ### sdac_sync2.v
// two-flop level synchroniser for pins arriving from other clock domains
`timescale 1ns/10ps
module sdac_sync2 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire clock,
    input wire rst_n,
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1;

    always @(posedge clock) begin
        if (!rst_n) begin
            stage1 <= RESET_VALUE;
            syncOut <= RESET_VALUE;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

// ### sdac_status_mem.v
// channel status word store, cleared on reset, registered read port
`timescale 1ns/10ps
module sdac_status_mem #(
    parameter WORDS = 6,
    parameter IDX_W = 3
) (
    input wire clock,
    input wire clear,
    input wire writeEn,
    input wire [IDX_W-1:0] writeIndex,
    input wire [31:0] writeData,
    input wire [IDX_W-1:0] readIndex,
    output reg [31:0] readData
);
    wire [32*WORDS-1:0] flat;

    genvar g;
    generate
        for (g = 0; g < WORDS; g = g + 1) begin : gWord
            reg [31:0] word;
            always @(posedge clock) begin
                if (clear) begin
                    word <= 32'h0000_0000;
                end else if (writeEn && writeIndex == g) begin
                    word <= writeData;
                end
            end
            assign flat[32*g +: 32] = word;
        end
    endgenerate

    always @(posedge clock) begin
        if (clear) begin
            readData <= 32'h0000_0000;
        end else if (readIndex < WORDS) begin
            readData <= flat[32*readIndex +: 32];
        end else begin
            readData <= 32'h0000_0000;
        end
    end
endmodule

// ### sdac_config_reset_ctrl.v
// register set, option readback and reset scopes of the sdi audio core
// Summary of operation
// - status bits 0 to 191 readable, reset zero
// - option bit 8: channel status capture built
// - option bit 7: register bus interface built
// - option bit 6: embed zero, extract one
// - option bits 5:4: link standard code
// - option bits 3:0: channel limit code
// - channel limit selects active group registers
// - channel limit written as plain count
// - group select value n means group n+1
// - registers live in host clock domain
// - bus reset restores registers and flags
// - stream reset clears stream clock logic
// - video reset spares registers and flags
// - config soft reset restores registers, flags
// - embedder core reset flushes fifo, stream
// - extractor core reset flushes fifo, stream, video
// - detection flags set by hardware, write-one-clear
`timescale 1ns/10ps
`include "sdac_map.vh"
module sdac_config_reset_ctrl #(
    parameter CHAN_STATUS_EXTRACT = 1,
    parameter INCLUDE_LITE = 1,
    parameter AUDIO_FUNCTION = 1,
    parameter [1:0] SDI_STANDARD = 2'h3,
    parameter [3:0] MAX_CHANNELS_CODE = 4'h7
) (
    input wire clock,
    input wire rst_n,
    input wire [`SDAC_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`SDAC_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire streamResetInN,
    input wire videoResetIn,
    input wire [`SDAC_NUM_EVENTS-1:0] detectEvent,
    input wire [3:0] groupPresent,
    input wire [27:0] ctrlPacketStatus,
    input wire csWrite,
    input wire [2:0] csIndex,
    input wire [31:0] csData,
    output reg coreEnable,
    output reg clkPhase,
    output reg [4:0] channelLimit,
    output reg [7:0] groupSelect,
    output reg [15:0] muteChannels,
    output reg [3:0] activeGroups,
    output reg [`SDAC_NUM_EVENTS-1:0] detectEnable,
    output reg videoLogicReset,
    output reg streamLogicReset,
    output reg fifoFlush
);
    localparam IS_EXTRACT = (AUDIO_FUNCTION != 0);

    reg softCfgPulse;
    reg softCore;
    reg [`SDAC_NUM_EVENTS-1:0] irqStatus;
    reg [5:0] demuxCtrl1;
    reg [5:0] demuxCtrl2;
    reg [5:0] demuxCtrl3;
    reg [5:0] demuxCtrl4;
    reg [3:0] groupPresentQ;
    reg [27:0] ctrlPacketQ;
    reg [`SDAC_ADDR_W-1:0] rdAddr;
    reg rdPending;
    reg [31:0] next_rdata;
    reg next_rdErr;

    wire cfgReset;
    wire writeTake;
    wire writeLow;
    wire readTake;
    wire [1:0] pinSync;
    wire [31:0] csWord;
    wire [31:0] optionWord;
    wire [2:0] csReadIndex;
    wire [`SDAC_ADDR_W-1:0] csOffset;
    wire writeMapped;

    // the soft config pulse lands on the register set one cycle after the write
    assign cfgReset = !rst_n || softCfgPulse;
    assign writeTake = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    assign writeLow = writeTake && s_axi_wstrb[0];
    assign readTake = s_axi_arvalid && !s_axi_arready && !rdPending && !s_axi_rvalid;
    assign csOffset = s_axi_araddr - `SDAC_OFF_CS_FIRST;
    assign csReadIndex = csOffset[4:2];

    assign optionWord = {
        23'h00_0000,
        (CHAN_STATUS_EXTRACT != 0) ? 1'b1 : 1'b0,
        (INCLUDE_LITE != 0) ? 1'b1 : 1'b0,
        IS_EXTRACT ? 1'b1 : 1'b0,
        SDI_STANDARD,
        MAX_CHANNELS_CODE
    };

    assign writeMapped = (s_axi_awaddr == `SDAC_OFF_ENABLE)
        || (s_axi_awaddr == `SDAC_OFF_SOFT_RESET)
        || (s_axi_awaddr == `SDAC_OFF_IRQ_ENABLE)
        || (s_axi_awaddr == `SDAC_OFF_IRQ_STATUS)
        || (s_axi_awaddr == `SDAC_OFF_AUDIO_CTRL)
        || (s_axi_awaddr == `SDAC_OFF_CHAN_LIMIT)
        || (s_axi_awaddr == `SDAC_OFF_GROUP_SEL1)
        || (s_axi_awaddr == `SDAC_OFF_GROUP_SEL2)
        || (s_axi_awaddr == `SDAC_OFF_GROUP_SEL3)
        || (s_axi_awaddr == `SDAC_OFF_GROUP_SEL4);

    // reset pins come from the stream and video domains
    sdac_sync2 #(
        .WIDTH(2),
        .RESET_VALUE(2'h1)
    ) uResetSync (
        .clock(clock),
        .rst_n(rst_n),
        .asyncIn({videoResetIn, streamResetInN}),
        .syncOut(pinSync)
    );

    // status words are cleared only by the register-side resets
    sdac_status_mem #(
        .WORDS(`SDAC_NUM_CS_WORDS),
        .IDX_W(3)
    ) uStatusMem (
        .clock(clock),
        .clear(cfgReset),
        .writeEn(csWrite && (CHAN_STATUS_EXTRACT != 0)),
        .writeIndex(csIndex),
        .writeData(csData),
        .readIndex(csReadIndex),
        .readData(csWord)
    );

    // self-clearing config soft reset; only the bus reset clears it
    always @(posedge clock) begin
        if (!rst_n) begin
            softCfgPulse <= 1'b0;
        end else begin
            softCfgPulse <= writeLow && (s_axi_awaddr == `SDAC_OFF_SOFT_RESET)
                && s_axi_wdata[`SDAC_SOFT_CFG_BIT];
        end
    end

    // register set
    always @(posedge clock) begin
        if (cfgReset) begin
            coreEnable <= 1'b0;
            softCore <= 1'b0;
            detectEnable <= {`SDAC_NUM_EVENTS{1'b0}};
            clkPhase <= `SDAC_CLK_PHASE_RESET;
            channelLimit <= 5'h00;
            demuxCtrl1 <= 6'h00;
            demuxCtrl2 <= 6'h00;
            demuxCtrl3 <= 6'h00;
            demuxCtrl4 <= 6'h00;
        end else if (writeLow) begin
            case (s_axi_awaddr)
                `SDAC_OFF_ENABLE: begin
                    coreEnable <= s_axi_wdata[0];
                end
                `SDAC_OFF_SOFT_RESET: begin
                    softCore <= s_axi_wdata[`SDAC_SOFT_CORE_BIT];
                end
                `SDAC_OFF_IRQ_ENABLE: begin
                    detectEnable <= s_axi_wdata[`SDAC_NUM_EVENTS-1:0];
                end
                `SDAC_OFF_AUDIO_CTRL: begin
                    clkPhase <= s_axi_wdata[0];
                end
                `SDAC_OFF_CHAN_LIMIT: begin
                    channelLimit <= s_axi_wdata[4:0];
                end
                `SDAC_OFF_GROUP_SEL1: begin
                    demuxCtrl1 <= s_axi_wdata[5:0];
                end
                `SDAC_OFF_GROUP_SEL2: begin
                    demuxCtrl2 <= s_axi_wdata[5:0];
                end
                `SDAC_OFF_GROUP_SEL3: begin
                    demuxCtrl3 <= s_axi_wdata[5:0];
                end
                `SDAC_OFF_GROUP_SEL4: begin
                    demuxCtrl4 <= s_axi_wdata[5:0];
                end
                default: begin
                    coreEnable <= coreEnable;
                end
            endcase
        end
    end

    // flags: a detection in the clearing cycle survives the clear
    always @(posedge clock) begin
        if (cfgReset) begin
            irqStatus <= {`SDAC_NUM_EVENTS{1'b0}};
        end else if (writeLow && s_axi_awaddr == `SDAC_OFF_IRQ_STATUS) begin
            irqStatus <= (irqStatus & ~s_axi_wdata[`SDAC_NUM_EVENTS-1:0])
                | (detectEvent & detectEnable);
        end else begin
            irqStatus <= irqStatus | (detectEvent & detectEnable);
        end
    end

    // datapath status snapshots and registered control outputs
    always @(posedge clock) begin
        if (!rst_n) begin
            groupPresentQ <= 4'h0;
            ctrlPacketQ <= 28'h000_0000;
            groupSelect <= 8'h00;
            muteChannels <= 16'h0000;
            activeGroups <= 4'h0;
        end else begin
            groupPresentQ <= groupPresent;
            ctrlPacketQ <= ctrlPacketStatus;
            groupSelect <= {demuxCtrl4[1:0], demuxCtrl3[1:0],
                demuxCtrl2[1:0], demuxCtrl1[1:0]};
            muteChannels <= {demuxCtrl4[5:2], demuxCtrl3[5:2],
                demuxCtrl2[5:2], demuxCtrl1[5:2]};
            if (channelLimit <= `SDAC_LIMIT_GROUP1) begin
                activeGroups <= 4'h1;
            end else if (channelLimit <= `SDAC_LIMIT_GROUP2) begin
                activeGroups <= 4'h3;
            end else if (channelLimit <= `SDAC_LIMIT_GROUP3) begin
                activeGroups <= 4'h7;
            end else begin
                activeGroups <= 4'hF;
            end
        end
    end

    // reset scopes; held active during bus reset so the datapath starts clean
    always @(posedge clock) begin
        if (!rst_n) begin
            videoLogicReset <= 1'b1;
            streamLogicReset <= 1'b1;
            fifoFlush <= 1'b1;
        end else begin
            videoLogicReset <= pinSync[1] || (IS_EXTRACT && softCore);
            streamLogicReset <= !pinSync[0] || softCore;
            fifoFlush <= softCore;
        end
    end

    // read mux, used in the cycle after the address is taken
    always @* begin
        next_rdata = 32'h0000_0000;
        next_rdErr = 1'b0;
        case (rdAddr)
            `SDAC_OFF_ENABLE: next_rdata = {31'h0000_0000, coreEnable};
            `SDAC_OFF_SOFT_RESET: next_rdata = {30'h0000_0000, softCore, 1'b0};
            `SDAC_OFF_IRQ_ENABLE: next_rdata = {26'h000_0000, detectEnable};
            `SDAC_OFF_IRQ_STATUS: next_rdata = {26'h000_0000, irqStatus};
            `SDAC_OFF_AUDIO_CTRL: next_rdata = {31'h0000_0000, clkPhase};
            `SDAC_OFF_CHAN_LIMIT: next_rdata = {27'h000_0000, channelLimit};
            `SDAC_OFF_GROUP_SEL1: next_rdata = {26'h000_0000, demuxCtrl1};
            `SDAC_OFF_GROUP_SEL2: next_rdata = {26'h000_0000, demuxCtrl2};
            `SDAC_OFF_GROUP_SEL3: next_rdata = {26'h000_0000, demuxCtrl3};
            `SDAC_OFF_GROUP_SEL4: next_rdata = {26'h000_0000, demuxCtrl4};
            `SDAC_OFF_GROUP_PRESENT: next_rdata = {28'h000_0000, groupPresentQ};
            `SDAC_OFF_CTRL_PKT: next_rdata = {4'h0, ctrlPacketQ};
            `SDAC_OFF_OPTIONS: next_rdata = optionWord;
            default: begin
                if (rdAddr >= `SDAC_OFF_CS_FIRST && rdAddr <= `SDAC_OFF_CS_LAST
                        && rdAddr[1:0] == 2'h0) begin
                    next_rdata = csWord;
                end else begin
                    next_rdErr = 1'b1;
                end
            end
        endcase
    end

    // write channel: address and data taken together, one response each
    always @(posedge clock) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SDAC_RESP_OKAY;
        end else begin
            s_axi_awready <= writeTake;
            s_axi_wready <= writeTake;
            if (writeTake) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= writeMapped ? `SDAC_RESP_OKAY : `SDAC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one wait cycle lets the status store produce its word
    always @(posedge clock) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            rdPending <= 1'b0;
            rdAddr <= 8'h00;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SDAC_RESP_OKAY;
        end else begin
            s_axi_arready <= readTake;
            if (readTake) begin
                rdAddr <= s_axi_araddr;
            end
            rdPending <= readTake;
            if (rdPending) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rdErr ? `SDAC_RESP_SLVERR : `SDAC_RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ### sdac_crc_checker.sv
// concurrent checks on the register bus and reset outputs of the audio config block
`timescale 1ns/10ps
module sdac_crc_checker #(
    parameter CHAN_STATUS_EXTRACT = 1,
    parameter INCLUDE_LITE = 1,
    parameter AUDIO_FUNCTION = 1,
    parameter [1:0] SDI_STANDARD = 2'h3,
    parameter [3:0] MAX_CHANNELS_CODE = 4'h7
) (
    input wire clock,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire streamResetInN,
    input wire videoResetIn,
    input wire csWrite,
    input wire [2:0] csIndex,
    input wire [31:0] csData,
    input wire coreEnable,
    input wire clkPhase,
    input wire [4:0] channelLimit,
    input wire [3:0] activeGroups,
    input wire [5:0] detectEnable,
    input wire videoLogicReset,
    input wire streamLogicReset,
    input wire fifoFlush
);
    localparam [31:0] OPT_WORD = {23'h00_0000, CHAN_STATUS_EXTRACT != 0, INCLUDE_LITE != 0,
        AUDIO_FUNCTION != 0, SDI_STANDARD, MAX_CHANNELS_CODE};
    wire wrTake = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    wire rdTake = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    wire softWr = wrTake && s_axi_wstrb[0] && s_axi_awaddr == 8'h04;
    reg [7:0] rdAddr;
    reg [31:0] csWord4;
    reg [31:0] csWord5;
    function [3:0] span(input [4:0] lim);
        span = (lim <= 5'h04) ? 4'h1 : (lim <= 5'h08) ? 4'h3 : (lim <= 5'h0C) ? 4'h7 : 4'hF;
    endfunction
    // shadow of the two upper status words, cleared like the register set
    always @(posedge clock) begin
        if (rdTake)
            rdAddr <= s_axi_araddr;
        if (!rst_n || (softWr && s_axi_wdata[0])) begin
            csWord4 <= 32'h0000_0000;
            csWord5 <= 32'h0000_0000;
        end else if (csWrite && CHAN_STATUS_EXTRACT != 0) begin
            if (csIndex == 3'h4)
                csWord4 <= csData;
            if (csIndex == 3'h5)
                csWord5 <= csData;
        end
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_write_answer: assert property (
        wrTake |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
        else $error("write not answered one cycle after take");
    a_read_answer: assert property (
        rdTake |=> s_axi_arready ##1 s_axi_rvalid)
        else $error("read not answered in time");
    a_option_word: assert property (
        s_axi_rvalid && rdAddr == 8'hFC |-> s_axi_rdata == OPT_WORD)
        else $error("option word does not match build");
    a_status_upper: assert property (
        s_axi_rvalid |-> (rdAddr != 8'h58 || s_axi_rdata == csWord4)
            && (rdAddr != 8'h5C || s_axi_rdata == csWord5))
        else $error("upper status word mismatch");
    a_reset_defaults: assert property (
        $rose(rst_n) |-> clkPhase && !coreEnable && channelLimit == 5'h00
            && detectEnable == 6'h00 && fifoFlush)
        else $error("bus reset left a register off its default");
    a_config_soft: assert property (
        softWr && s_axi_wdata[0] |-> ##[1:2] clkPhase && !coreEnable
            && channelLimit == 5'h00 && detectEnable == 6'h00)
        else $error("config soft reset did not restore registers");
    a_core_flush: assert property (
        softWr && !s_axi_wdata[0] |-> ##2 fifoFlush == $past(s_axi_wdata[1], 2))
        else $error("fifo flush does not follow core soft reset");
    a_core_scope: assert property (
        softWr && s_axi_wdata[1] && !s_axi_wdata[0]
            |-> ##2 streamLogicReset && (AUDIO_FUNCTION == 0 || videoLogicReset))
        else $error("core soft reset missed a datapath reset");
    a_stream_pin: assert property (
        !streamResetInN [*4] |-> streamLogicReset)
        else $error("stream reset pin not reaching stream logic");
    a_video_pin: assert property (
        videoResetIn [*4] |-> videoLogicReset)
        else $error("video reset pin not reaching video logic");
    a_group_span: assert property (
        $past(rst_n) && $stable(channelLimit) |-> activeGroups == span(channelLimit))
        else $error("active groups do not match channel limit");
    c_soft_write: cover property (softWr);
    c_option_read: cover property (s_axi_rvalid && rdAddr == 8'hFC);
    c_refused_read: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind sdac_config_reset_ctrl sdac_crc_checker #(
    .CHAN_STATUS_EXTRACT(CHAN_STATUS_EXTRACT), .INCLUDE_LITE(INCLUDE_LITE),
    .AUDIO_FUNCTION(AUDIO_FUNCTION), .SDI_STANDARD(SDI_STANDARD),
    .MAX_CHANNELS_CODE(MAX_CHANNELS_CODE)
) u_checker (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .streamResetInN, .videoResetIn,
    .csWrite, .csIndex, .csData, .coreEnable, .clkPhase, .channelLimit, .activeGroups,
    .detectEnable, .videoLogicReset, .streamLogicReset, .fifoFlush);

// ### sdac_host_model.sv
// host processor model: one write or read at a time on the register bus
`timescale 1ns/10ps
module sdac_host_model (
    input wire clock,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire [1:0] s_axi_bresp,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = 52'h0_0000_0000_0000;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    end
    // each call starts one edge after the last release, so no pin toggles twice in a step
    task automatic wr(input [7:0] addr, input [31:0] data, output [1:0] resp);
        @(posedge clock);
        #1;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} = {addr, data, 4'hF};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h7;
        do @(posedge clock); while (!s_axi_awready);
        resp = s_axi_bresp;
        #1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        // released address and data lines carry garbage, never the last value
        {s_axi_awaddr, s_axi_wdata} = ~{addr, data};
    endtask
    task automatic rd(input [7:0] addr, output [31:0] data, output [1:0] resp);
        @(posedge clock);
        #1;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = {addr, 2'h3};
        do @(posedge clock); while (!s_axi_arready);
        #1;
        {s_axi_araddr, s_axi_arvalid} = {~addr, 1'b0};
        do @(posedge clock); while (!s_axi_rvalid);
        {data, resp} = {s_axi_rdata, s_axi_rresp};
        #1;
        s_axi_rready = 1'b0;
    endtask
endmodule

// ### sdac_config_reset_ctrl_bench.sv
// self-checking bench for the audio config and reset block
`timescale 1ns/10ps
module sdac_config_reset_ctrl_bench;
    localparam [1:0] STD = 2'h1;
    localparam [3:0] MAXC = 4'h5;
    localparam [31:0] OPT = {23'h00_0000, 3'h7, STD, MAXC};
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg streamResetInN = 1'b1;
    reg videoResetIn = 1'b0;
    reg [5:0] detectEvent = 6'h00;
    reg [3:0] groupPresent = 4'hA;
    reg [27:0] ctrlPacketStatus = 28'h123_4567;
    reg csWrite = 1'b0;
    reg [2:0] csIndex = 3'h0;
    reg [31:0] csData = 32'h0000_0000;
    wire [7:0] s_axi_awaddr, s_axi_araddr, groupSelect;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [3:0] s_axi_wstrb, activeGroups;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire coreEnable, clkPhase, videoLogicReset, streamLogicReset, fifoFlush;
    wire [4:0] channelLimit;
    wire [15:0] muteChannels;
    wire [5:0] detectEnable;
    integer error_cnt = 0;
    integer total_checks = 0;
    integer cycles = 0;
    integer i;
    reg [31:0] rdata;
    reg [1:0] resp;

    sdac_config_reset_ctrl #(.SDI_STANDARD(STD), .MAX_CHANNELS_CODE(MAXC)) i_sdac_config_reset_ctrl (
        .clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .streamResetInN, .videoResetIn, .detectEvent, .groupPresent, .ctrlPacketStatus, .csWrite,
        .csIndex, .csData, .coreEnable, .clkPhase, .channelLimit, .groupSelect, .muteChannels,
        .activeGroups, .detectEnable, .videoLogicReset, .streamLogicReset, .fifoFlush);
    sdac_host_model hostModel (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_bresp, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    always #12.5 clock = ~clock;
    task conclude;
        if (error_cnt == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // whole sequence needs well under a thousand cycles
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            error_cnt = error_cnt + 1;
            conclude;
        end
    end
    task check(input [31:0] seen, input [31:0] exp, input string what);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            error_cnt = error_cnt + 1;
        end
    endtask
    task wreg(input [7:0] a, input [31:0] d, input [1:0] er);
        hostModel.wr(a, d, resp);
        check(resp, er, $sformatf("write response %h", a));
    endtask
    // only 0x80 is used as an unmapped place
    task rreg(input [7:0] a, input [31:0] e);
        hostModel.rd(a, rdata, resp);
        check(rdata, e, $sformatf("read data %h", a));
        check(resp, (a == 8'h80) ? 2'h2 : 2'h0, $sformatf("read response %h", a));
    endtask
    task pulse_events(input [5:0] ev);
        @(posedge clock);
        #1 detectEvent = ev;
        @(posedge clock);
        #1 detectEvent = 6'h00;
    endtask

    initial begin
        repeat (12) @(posedge clock);
        #1 rst_n = 1'b1;
        rreg(8'hFC, OPT);
        rreg(8'h5C, 32'h0000_0000);
        rreg(8'h18, 32'h0000_0001);
        rreg(8'h40, 32'h0000_000A);
        rreg(8'h44, 32'h0123_4567);
        wreg(8'h04, 32'h0000_0002, 2'h0);
        check({fifoFlush, streamLogicReset, videoLogicReset}, 3'h7, "core resets");
        wreg(8'h0C, 32'h0000_003F, 2'h0);
        check(detectEnable, 6'h3F, "detect enable");
        for (i = 1; i <= 8; i = i + 1) begin
            wreg(8'h1C, 2 * i, 2'h0);
            check(channelLimit, 2 * i, "channel limit");
            check(activeGroups, (i < 3) ? 4'h1 : (i < 5) ? 4'h3 : (i < 7) ? 4'h7 : 4'hF, "groups");
        end
        for (i = 0; i < 4; i = i + 1)
            wreg(8'h20 + 8'(4 * i), (i == 2) ? 32'h0000_003E : i, 2'h0);
        wreg(8'h04, 32'h0000_0000, 2'h0);
        wreg(8'h00, 32'h0000_0001, 2'h0);
        check(groupSelect, 8'hE4, "group select");
        check(muteChannels, 16'h0F00, "mute channels");
        check({coreEnable, fifoFlush, streamLogicReset, videoLogicReset}, 4'h8, "run");
        pulse_events(6'h21);
        rreg(8'h10, 32'h0000_0021);
        wreg(8'h10, 32'h0000_0001, 2'h0);
        rreg(8'h10, 32'h0000_0020);
        fork
            pulse_events(6'h01);
            wreg(8'h10, 32'h0000_0021, 2'h0);
        join
        rreg(8'h10, 32'h0000_0001);
        wreg(8'h0C, 32'h0000_0000, 2'h0);
        pulse_events(6'h02);
        rreg(8'h10, 32'h0000_0001);
        wreg(8'hFC, 32'h0000_0000, 2'h2);
        wreg(8'h5C, 32'hFFFF_FFFF, 2'h2);
        wreg(8'h80, 32'h0000_0001, 2'h2);
        rreg(8'h80, 32'h0000_0000);
        @(posedge clock);
        #1 {csWrite, csIndex, csData} = {1'b1, 3'h4, 32'hA5C3_0F12};
        @(posedge clock);
        #1 {csIndex, csData} = {3'h5, 32'h5A3C_F0ED};
        @(posedge clock);
        #1 csWrite = 1'b0;
        rreg(8'h58, 32'hA5C3_0F12);
        videoResetIn = 1'b1;
        repeat (5) @(posedge clock);
        #1 check(videoLogicReset, 1'b1, "video reset");
        videoResetIn = 1'b0;
        rreg(8'h5C, 32'h5A3C_F0ED);
        rreg(8'h1C, 32'h0000_0010);
        streamResetInN = 1'b0;
        repeat (5) @(posedge clock);
        #1 check(streamLogicReset, 1'b1, "stream reset");
        streamResetInN = 1'b1;
        repeat (5) @(posedge clock);
        #1 check(streamLogicReset, 1'b0, "stream release");
        wreg(8'h04, 32'h0000_0001, 2'h0);
        rreg(8'h00, 32'h0000_0000);
        rreg(8'h10, 32'h0000_0000);
        rreg(8'h58, 32'h0000_0000);
        rreg(8'h04, 32'h0000_0000);
        wreg(8'h1C, 32'h0000_0006, 2'h0);
        wreg(8'h18, 32'h0000_0000, 2'h0);
        rst_n = 1'b0;
        repeat (12) @(posedge clock);
        #1 rst_n = 1'b1;
        rreg(8'h1C, 32'h0000_0000);
        rreg(8'h18, 32'h0000_0001);
        conclude;
    end
endmodule
